// ===== sfe_map.vh
`ifndef SFE_MAP_VH
`define SFE_MAP_VH

// operation size field
`define SFE_SZ_BYTE      2'h0
`define SFE_SZ_WORD      2'h1
`define SFE_SZ_LONG      2'h2
`define SFE_SZ_BAD       2'h3

// destination mode field
`define SFE_MD_DREG      3'h0
`define SFE_MD_AREG      3'h1
`define SFE_MD_IND       3'h2
`define SFE_MD_POSTINC   3'h3
`define SFE_MD_PREDEC    3'h4
`define SFE_MD_DISP16    3'h5
`define SFE_MD_INDEX     3'h6
`define SFE_MD_EXT       3'h7

// register subfield under mode 111
`define SFE_ABS_SHORT    3'h0
`define SFE_ABS_LONG     3'h1

// opcode recognition patterns
`define SFE_OP_IMM_HI    8'h04
`define SFE_OP_QUICK_HI  4'h5
`define SFE_OP_EXT_HI    4'h9
`define SFE_OP_SWAP_HI   13'h0908

// flag vector positions {x,n,z,v,c}
`define SFE_FX           4
`define SFE_FN           3
`define SFE_FZ           2
`define SFE_FV           1
`define SFE_FC           0
`define SFE_FLAGS_RST    5'h00

`endif

// ===== sfe_decode.v
`timescale 1ns/1ps
`include "sfe_map.vh"

module sfe_decode
(
    // opcode in
    input  wire [15:0] i_opcode,
    // decoded fields
    output reg         o_is_imm,
    output reg         o_is_quick,
    output reg         o_is_ext,
    output reg         o_is_swap,
    output wire [1:0]  o_size,
    output wire [2:0]  o_mode,
    output wire [2:0]  o_reg_lo,
    output wire [2:0]  o_reg_hi,
    output wire        o_rm,
    output wire [3:0]  o_quick_val,
    output reg         o_illegal
);

    wire       bad_ext_mode;

    assign o_size   = i_opcode[7:6];
    assign o_mode   = i_opcode[5:3];
    assign o_reg_lo = i_opcode[2:0];
    assign o_reg_hi = i_opcode[11:9];
    assign o_rm     = i_opcode[3];
    // code 0 stands for eight
    assign o_quick_val = (i_opcode[11:9] == 3'h0) ? 4'h8 : {1'b0, i_opcode[11:9]};
    // only absolute short and long are alterable under mode 111
    assign bad_ext_mode = (o_mode == `SFE_MD_EXT) && (o_reg_lo != `SFE_ABS_SHORT)
                          && (o_reg_lo != `SFE_ABS_LONG);

    always @*
    begin
        o_is_imm   = (i_opcode[15:8] == `SFE_OP_IMM_HI);
        o_is_quick = (i_opcode[15:12] == `SFE_OP_QUICK_HI) && i_opcode[8];
        o_is_ext   = (i_opcode[15:12] == `SFE_OP_EXT_HI) && i_opcode[8]
                     && (i_opcode[5:4] == 2'h0);
        o_is_swap  = (i_opcode[15:3] == `SFE_OP_SWAP_HI);
        o_illegal  = 1'b0;
        if (o_is_imm)
        begin
            o_illegal = (o_size == `SFE_SZ_BAD) || (o_mode == `SFE_MD_AREG)
                        || bad_ext_mode;
        end
        else if (o_is_quick)
        begin
            o_illegal = (o_size == `SFE_SZ_BAD) || bad_ext_mode
                        || ((o_mode == `SFE_MD_AREG) && (o_size == `SFE_SZ_BYTE));
        end
        else if (o_is_ext)
        begin
            o_illegal = (o_size == `SFE_SZ_BAD);
        end
    end

endmodule

// ===== sfe_alu.v
`timescale 1ns/1ps
`include "sfe_map.vh"

module sfe_alu
(
    // operands
    input  wire [31:0] i_dst,
    input  wire [31:0] i_src,
    input  wire        i_xin,
    input  wire [1:0]  i_size,
    // result and flags
    output reg  [31:0] o_result,
    output reg         o_neg,
    output reg         o_zero,
    output reg         o_ovf,
    output reg         o_borrow
);

    wire [8:0]  diff_b;
    wire [16:0] diff_w;
    wire [32:0] diff_l;

    // one subtractor per width keeps the borrow out of the upper bits
    assign diff_b = {1'b0, i_dst[7:0]} - {1'b0, i_src[7:0]} - {8'h00, i_xin};
    assign diff_w = {1'b0, i_dst[15:0]} - {1'b0, i_src[15:0]} - {16'h0000, i_xin};
    assign diff_l = {1'b0, i_dst} - {1'b0, i_src} - {32'h00000000, i_xin};

    always @*
    begin
        case (i_size)
            `SFE_SZ_BYTE:
            begin
                o_result = {i_dst[31:8], diff_b[7:0]};
                o_neg    = diff_b[7];
                o_zero   = (diff_b[7:0] == 8'h00);
                o_borrow = diff_b[8];
                o_ovf    = (i_dst[7] ^ i_src[7]) & (i_dst[7] ^ diff_b[7]);
            end
            `SFE_SZ_WORD:
            begin
                o_result = {i_dst[31:16], diff_w[15:0]};
                o_neg    = diff_w[15];
                o_zero   = (diff_w[15:0] == 16'h0000);
                o_borrow = diff_w[16];
                o_ovf    = (i_dst[15] ^ i_src[15]) & (i_dst[15] ^ diff_w[15]);
            end
            default:
            begin
                o_result = diff_l[31:0];
                o_neg    = diff_l[31];
                o_zero   = (diff_l[31:0] == 32'h00000000);
                o_borrow = diff_l[32];
                o_ovf    = (i_dst[31] ^ i_src[31]) & (i_dst[31] ^ diff_l[31]);
            end
        endcase
    end

endmodule

// ===== sfe_exec.v
`timescale 1ns/1ps
`include "sfe_map.vh"

// Overview of operation
// - immediate subtract: destination minus same-size immediate
// - size field 00 byte, 01 word, 10 long
// - immediate from following words, per size
// - immediate/quick set N Z V C from result, except quick to address
// - extend flag copies carry on subtract flag updates
// - immediate destination must be data alterable
// - decode destination mode field and absolute subfield
// - quick data 1 to 7, zero means eight
// - quick to address: no byte, 32-bit, no flags
// - quick destination alterable, no immediate or pc
// - extended: destination minus source minus extend
// - rm bit: registers or predecrement memory
// - bits 11-9 destination, bits 2-0 source
// - extended sets N V C from result
// - extended clears zero only on nonzero result
// - swap exchanges data register halves
// - swap: N bit31, Z, clear V C

module sfe_exec
(
    // clock and reset
    input  wire        i_sys_clk,
    input  wire        i_reset_n,
    // opcode from sequencer
    input  wire        i_op_valid,
    input  wire [15:0] i_opcode,
    // extension words
    input  wire        i_ext_valid,
    input  wire [15:0] i_ext_word,
    // operands from sequencer
    input  wire        i_opnd_valid,
    input  wire [31:0] i_dst_data,
    input  wire [31:0] i_src_data,
    // software flag load {x,n,z,v,c}
    input  wire        i_flag_load,
    input  wire [4:0]  i_flag_value,
    // handshake to sequencer
    output wire        o_ready,
    output wire        o_ext_req,
    output wire        o_opnd_req,
    output wire        o_illegal,
    // operand access description
    output wire [1:0]  o_size,
    output wire [2:0]  o_dst_mode,
    output wire [2:0]  o_dst_reg,
    output wire [2:0]  o_src_reg,
    output wire        o_src_used,
    output wire        o_predec,
    // result
    output wire        o_wr_valid,
    output wire [31:0] o_result,
    // condition flags
    output wire        o_flag_x,
    output wire        o_flag_n,
    output wire        o_flag_z,
    output wire        o_flag_v,
    output wire        o_flag_c
);

    localparam ST_IDLE = 3'h1;
    localparam ST_EXT  = 3'h2;
    localparam ST_OPND = 3'h4;

    localparam K_IMM   = 4'h1;
    localparam K_QUICK = 4'h2;
    localparam K_EXT   = 4'h4;
    localparam K_SWAP  = 4'h8;

    // decoder outputs
    wire        dec_imm;
    wire        dec_quick;
    wire        dec_ext;
    wire        dec_swap;
    wire [1:0]  dec_size;
    wire [2:0]  dec_mode;
    wire [2:0]  dec_reg_lo;
    wire [2:0]  dec_reg_hi;
    wire        dec_rm;
    wire [3:0]  dec_qval;
    wire        dec_illegal;

    // alu
    wire [31:0] alu_src;
    wire [1:0]  alu_size;
    wire        alu_xin;
    wire [31:0] alu_res;
    wire        alu_n;
    wire        alu_z;
    wire        alu_v;
    wire        alu_c;
    wire [31:0] swap_res;
    wire        quick_areg;

    // state
    reg  [2:0]  state_reg;
    reg  [3:0]  kind_reg;
    reg  [3:0]  qval_reg;
    reg  [31:0] imm_reg;
    reg         ext_cnt_reg;
    reg         ready_reg;
    reg         ext_req_reg;
    reg         opnd_req_reg;
    reg         illegal_reg;
    reg  [1:0]  size_reg;
    reg  [2:0]  dst_mode_reg;
    reg  [2:0]  dst_reg_reg;
    reg  [2:0]  src_reg_reg;
    reg         src_used_reg;
    reg         predec_reg;
    reg         wr_valid_reg;
    reg  [31:0] result_reg;
    reg  [4:0]  flags_reg;

    sfe_decode u_decode
    (
        .i_opcode    (i_opcode),
        .o_is_imm    (dec_imm),
        .o_is_quick  (dec_quick),
        .o_is_ext    (dec_ext),
        .o_is_swap   (dec_swap),
        .o_size      (dec_size),
        .o_mode      (dec_mode),
        .o_reg_lo    (dec_reg_lo),
        .o_reg_hi    (dec_reg_hi),
        .o_rm        (dec_rm),
        .o_quick_val (dec_qval),
        .o_illegal   (dec_illegal)
    );

    // quick to an address register works on all 32 bits
    assign quick_areg = (kind_reg == K_QUICK) && (dst_mode_reg == `SFE_MD_AREG);

    assign alu_size = quick_areg ? `SFE_SZ_LONG : size_reg;
    assign alu_xin  = (kind_reg == K_EXT) ? flags_reg[`SFE_FX] : 1'b0;

    assign alu_src = (kind_reg == K_EXT)   ? i_src_data :
                     (kind_reg == K_QUICK) ? {28'h0000000, qval_reg} :
                     imm_reg;

    assign swap_res = {i_dst_data[15:0], i_dst_data[31:16]};

    sfe_alu u_alu
    (
        .i_dst    (i_dst_data),
        .i_src    (alu_src),
        .i_xin    (alu_xin),
        .i_size   (alu_size),
        .o_result (alu_res),
        .o_neg    (alu_n),
        .o_zero   (alu_z),
        .o_ovf    (alu_v),
        .o_borrow (alu_c)
    );

    always @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            state_reg    <= ST_IDLE;
            kind_reg     <= 4'h0;
            qval_reg     <= 4'h0;
            imm_reg      <= 32'h00000000;
            ext_cnt_reg  <= 1'b0;
            ready_reg    <= 1'b0;
            ext_req_reg  <= 1'b0;
            opnd_req_reg <= 1'b0;
            illegal_reg  <= 1'b0;
            size_reg     <= 2'h0;
            dst_mode_reg <= 3'h0;
            dst_reg_reg  <= 3'h0;
            src_reg_reg  <= 3'h0;
            src_used_reg <= 1'b0;
            predec_reg   <= 1'b0;
            wr_valid_reg <= 1'b0;
            result_reg   <= 32'h00000000;
            flags_reg    <= `SFE_FLAGS_RST;
        end
        else
        begin
            illegal_reg  <= 1'b0;
            wr_valid_reg <= 1'b0;
            // instruction flag writes override a load
            if (i_flag_load)
            begin
                flags_reg <= i_flag_value;
            end
            case (state_reg)
                ST_IDLE:
                begin
                    ready_reg <= 1'b1;
                    if (i_op_valid && ready_reg)
                    begin
                        size_reg    <= dec_size;
                        qval_reg    <= dec_qval;
                        ext_cnt_reg <= 1'b0;
                        predec_reg  <= 1'b0;
                        if (dec_illegal || !(dec_imm || dec_quick || dec_ext || dec_swap))
                        begin
                            // no subtraction, sequencer takes the trap
                            illegal_reg <= 1'b1;
                        end
                        else if (dec_imm)
                        begin
                            kind_reg     <= K_IMM;
                            dst_mode_reg <= dec_mode;
                            dst_reg_reg  <= dec_reg_lo;
                            src_used_reg <= 1'b0;
                            ready_reg    <= 1'b0;
                            ext_req_reg  <= 1'b1;
                            state_reg    <= ST_EXT;
                        end
                        else if (dec_quick)
                        begin
                            kind_reg     <= K_QUICK;
                            dst_mode_reg <= dec_mode;
                            dst_reg_reg  <= dec_reg_lo;
                            src_used_reg <= 1'b0;
                            ready_reg    <= 1'b0;
                            opnd_req_reg <= 1'b1;
                            state_reg    <= ST_OPND;
                        end
                        else if (dec_ext)
                        begin
                            kind_reg     <= K_EXT;
                            // memory form uses predecrement on both address registers
                            dst_mode_reg <= dec_rm ? `SFE_MD_PREDEC : `SFE_MD_DREG;
                            predec_reg   <= dec_rm;
                            dst_reg_reg  <= dec_reg_hi;
                            src_reg_reg  <= dec_reg_lo;
                            src_used_reg <= 1'b1;
                            ready_reg    <= 1'b0;
                            opnd_req_reg <= 1'b1;
                            state_reg    <= ST_OPND;
                        end
                        else
                        begin
                            kind_reg     <= K_SWAP;
                            size_reg     <= `SFE_SZ_LONG;
                            dst_mode_reg <= `SFE_MD_DREG;
                            dst_reg_reg  <= dec_reg_lo;
                            src_used_reg <= 1'b0;
                            ready_reg    <= 1'b0;
                            opnd_req_reg <= 1'b1;
                            state_reg    <= ST_OPND;
                        end
                    end
                end
                ST_EXT:
                begin
                    if (i_ext_valid)
                    begin
                        if ((size_reg == `SFE_SZ_LONG) && !ext_cnt_reg)
                        begin
                            // first of two words is the high half
                            imm_reg[31:16] <= i_ext_word;
                            ext_cnt_reg    <= 1'b1;
                        end
                        else
                        begin
                            ext_req_reg  <= 1'b0;
                            opnd_req_reg <= 1'b1;
                            state_reg    <= ST_OPND;
                            if (size_reg == `SFE_SZ_BYTE)
                            begin
                                imm_reg <= {24'h000000, i_ext_word[7:0]};
                            end
                            else if (size_reg == `SFE_SZ_WORD)
                            begin
                                imm_reg <= {16'h0000, i_ext_word};
                            end
                            else
                            begin
                                imm_reg[15:0] <= i_ext_word;
                            end
                        end
                    end
                end
                ST_OPND:
                begin
                    if (i_opnd_valid)
                    begin
                        opnd_req_reg <= 1'b0;
                        wr_valid_reg <= 1'b1;
                        ready_reg    <= 1'b1;
                        state_reg    <= ST_IDLE;
                        if (kind_reg == K_SWAP)
                        begin
                            result_reg           <= swap_res;
                            flags_reg[`SFE_FN]   <= swap_res[31];
                            flags_reg[`SFE_FZ]   <= (swap_res == 32'h00000000);
                            flags_reg[`SFE_FV]   <= 1'b0;
                            flags_reg[`SFE_FC]   <= 1'b0;
                        end
                        else if (quick_areg)
                        begin
                            result_reg <= alu_res;
                        end
                        else if (kind_reg == K_EXT)
                        begin
                            result_reg         <= alu_res;
                            flags_reg[`SFE_FN] <= alu_n;
                            flags_reg[`SFE_FV] <= alu_v;
                            flags_reg[`SFE_FC] <= alu_c;
                            flags_reg[`SFE_FX] <= alu_c;
                            // zero only falls, so a chain reports the whole result
                            if (!alu_z)
                            begin
                                flags_reg[`SFE_FZ] <= 1'b0;
                            end
                        end
                        else
                        begin
                            result_reg         <= alu_res;
                            flags_reg[`SFE_FN] <= alu_n;
                            flags_reg[`SFE_FZ] <= alu_z;
                            flags_reg[`SFE_FV] <= alu_v;
                            flags_reg[`SFE_FC] <= alu_c;
                            flags_reg[`SFE_FX] <= alu_c;
                        end
                    end
                end
                default:
                begin
                    state_reg    <= ST_IDLE;
                    ready_reg    <= 1'b0;
                    ext_req_reg  <= 1'b0;
                    opnd_req_reg <= 1'b0;
                end
            endcase
        end
    end

    assign o_ready    = ready_reg;
    assign o_ext_req  = ext_req_reg;
    assign o_opnd_req = opnd_req_reg;
    assign o_illegal  = illegal_reg;
    assign o_size     = size_reg;
    assign o_dst_mode = dst_mode_reg;
    assign o_dst_reg  = dst_reg_reg;
    assign o_src_reg  = src_reg_reg;
    assign o_src_used = src_used_reg;
    assign o_predec   = predec_reg;
    assign o_wr_valid = wr_valid_reg;
    assign o_result   = result_reg;
    assign o_flag_x   = flags_reg[`SFE_FX];
    assign o_flag_n   = flags_reg[`SFE_FN];
    assign o_flag_z   = flags_reg[`SFE_FZ];
    assign o_flag_v   = flags_reg[`SFE_FV];
    assign o_flag_c   = flags_reg[`SFE_FC];

endmodule

// ===== sfe_exec_sva.sv
`timescale 1ns/1ps
`include "sfe_map.vh"
module sfe_exec_sva (
    // clock and inputs
    input wire logic        i_sys_clk,
    input wire logic        i_reset_n,
    input wire logic        i_op_valid,
    input wire logic [15:0] i_opcode,
    input wire logic        i_opnd_valid,
    input wire logic [31:0] i_dst_data,
    input wire logic        i_flag_load,
    // outputs
    input wire logic        o_ready,
    input wire logic        o_opnd_req,
    input wire logic        o_illegal,
    input wire logic        o_wr_valid,
    input wire logic [31:0] o_result,
    input wire logic        o_flag_x,
    input wire logic        o_flag_n,
    input wire logic        o_flag_z,
    input wire logic        o_flag_v,
    input wire logic        o_flag_c
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    logic [15:0] op_q;
    logic [31:0] dst_q;
    wire         take = i_op_valid && o_ready;
    wire         in_i = i_opcode[15:8] == `SFE_OP_IMM_HI;
    wire         in_q = i_opcode[15:12] == `SFE_OP_QUICK_HI && i_opcode[8];
    wire         is_q = op_q[15:12] == `SFE_OP_QUICK_HI && op_q[8];
    wire         is_a = is_q && op_q[5:3] == `SFE_MD_AREG;
    wire         is_x = op_q[15:12] == `SFE_OP_EXT_HI && op_q[8] && op_q[5:4] == 2'h0;
    wire         is_s = op_q[15:3] == `SFE_OP_SWAP_HI;
    wire [31:0]  qv   = {28'h0000000, op_q[11:9] == 3'h0, op_q[11:9]};
    wire [4:0]   flg  = {o_flag_x, o_flag_n, o_flag_z, o_flag_v, o_flag_c};
    // cause of each result, held for the checks
    always @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
            op_q <= 16'h0000;
        else if (take)
            op_q <= i_opcode;
        if (i_opnd_valid && o_opnd_req)
            dst_q <= i_dst_data;
    end
    a_bad_size: assert property (take && (in_i || in_q) && i_opcode[7:6] == 2'h3
        |=> o_illegal && o_ready) else $error("bad size not refused");
    a_imm_areg: assert property (take && in_i && i_opcode[5:3] == `SFE_MD_AREG
        |=> o_illegal) else $error("address destination not refused");
    a_quick_bytea: assert property (take && in_q && i_opcode[7:3] == 5'h01
        |=> o_illegal) else $error("byte quick to address not refused");
    a_op_done: assert property (i_opnd_valid && o_opnd_req |=> o_wr_valid && o_ready
        && !o_opnd_req) else $error("operand take without result");
    a_quick_data: assert property (o_wr_valid && is_q && op_q[7:3] == 5'h10
        |-> o_result == dst_q - qv) else $error("quick result wrong");
    a_quick_addr: assert property (o_wr_valid && is_a && !$past(i_flag_load)
        |-> flg == $past(flg) && o_result == dst_q - qv) else $error("quick address wrong");
    a_x_copies_c: assert property (o_wr_valid && !is_s && !is_a
        |-> o_flag_x == o_flag_c) else $error("extend differs from carry");
    a_ext_zero: assert property (o_wr_valid && is_x && op_q[7:6] == 2'h2
        && o_result != 32'h0 |-> !o_flag_z) else $error("zero kept on nonzero");
    a_swap_flags: assert property (o_wr_valid && is_s |-> !o_flag_v && !o_flag_c
        && o_flag_n == o_result[31] && o_flag_z == (o_result == 32'h0)
        && o_result == {dst_q[15:0], dst_q[31:16]}) else $error("swap wrong");
    c_ext: cover property (o_wr_valid && is_x);
    c_swap: cover property (o_wr_valid && is_s);
    c_bad: cover property (o_illegal);
endmodule
bind sfe_exec sfe_exec_sva sfe_exec_sva_i (.*);

// ===== sfe_seq_model.sv
`timescale 1ns/1ps
`include "sfe_map.vh"
module sfe_seq_model (
    // design side
    input  wire logic        i_sys_clk,
    input  wire logic        i_ext_req,
    input  wire logic        i_opnd_req,
    input  wire logic [1:0]  i_size,
    // values set by the test
    input  wire logic [31:0] i_imm,
    input  wire logic [31:0] i_dst,
    input  wire logic [31:0] i_src,
    input  wire logic [3:0]  i_gap,
    // answers
    output logic             o_ext_valid = 1'b0,
    output logic [15:0]      o_ext_word = 16'h0000,
    output logic             o_opnd_valid = 1'b0,
    output logic [31:0]      o_dst_data = 32'h0,
    output logic [31:0]      o_src_data = 32'h0
);
    logic [3:0] wait_cnt = 4'h0;
    logic       word_idx = 1'b0;
    wire        go = wait_cnt >= i_gap;
    // idle lines toggle so stale data never passes as fresh
    always @(negedge i_sys_clk)
    begin
        o_ext_valid <= i_ext_req && go;
        o_opnd_valid <= i_opnd_req && go;
        if (i_ext_req && go)
            o_ext_word <= (i_size == `SFE_SZ_LONG && !word_idx) ? i_imm[31:16]
                          : i_imm[15:0];
        else
            o_ext_word <= ~o_ext_word;
        o_dst_data <= (i_opnd_req && go) ? i_dst : ~o_dst_data;
        o_src_data <= (i_opnd_req && go) ? i_src : ~o_src_data;
    end
    always @(posedge i_sys_clk)
    begin
        if ((o_ext_valid && i_ext_req) || (o_opnd_valid && i_opnd_req)
            || !(i_ext_req || i_opnd_req))
            wait_cnt <= 4'h0;
        else
            wait_cnt <= wait_cnt + 4'h1;
        if (o_ext_valid && i_ext_req)
            word_idx <= 1'b1;
        else if (!i_ext_req)
            word_idx <= 1'b0;
    end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
`include "sfe_map.vh"
module tb;
    logic        i_sys_clk = 1'b0;
    logic        i_reset_n = 1'b0;
    logic        i_op_valid = 1'b0;
    logic [15:0] i_opcode = 16'h0000;
    logic        i_flag_load = 1'b0;
    logic [4:0]  i_flag_value = 5'h00;
    logic [31:0] imm = 32'h0, dst = 32'h0, src = 32'h0;
    logic [3:0]  gap = 4'h0;
    logic [4:0]  ef;
    logic [36:0] r;
    integer      error_cnt = 0, check_count = 0, cyc = 0, i;
    logic [15:0] bad_op [0:5] = '{16'h04C0, 16'h0448, 16'h047C, 16'h5309, 16'h537A, 16'h93C1};
    logic [15:0] ext_op [0:2] = '{16'h9782, 16'h9549, 16'h9380};
    logic [31:0] ext_d [0:2] = '{32'h5, 32'h10, 32'h0};
    logic [31:0] ext_s [0:2] = '{32'h4, 32'h10, 32'h1};
    wire         i_ext_valid, i_opnd_valid, o_ready, o_ext_req, o_opnd_req, o_illegal;
    wire         o_src_used, o_predec, o_wr_valid;
    wire [15:0]  i_ext_word;
    wire [31:0]  i_dst_data, i_src_data, o_result;
    wire [1:0]   o_size;
    wire [2:0]   o_dst_mode, o_dst_reg, o_src_reg;
    wire [4:0]   flg;

    always #4 i_sys_clk = ~i_sys_clk;

    sfe_exec sfe_exec_i (.i_sys_clk, .i_reset_n, .i_op_valid, .i_opcode, .i_ext_valid,
        .i_ext_word, .i_opnd_valid, .i_dst_data, .i_src_data, .i_flag_load, .i_flag_value,
        .o_ready, .o_ext_req, .o_opnd_req, .o_illegal, .o_size, .o_dst_mode, .o_dst_reg,
        .o_src_reg, .o_src_used, .o_predec, .o_wr_valid, .o_result, .o_flag_x(flg[4]),
        .o_flag_n(flg[3]), .o_flag_z(flg[2]), .o_flag_v(flg[1]), .o_flag_c(flg[0]));
    sfe_seq_model sfe_seq_model_i (.i_sys_clk, .i_ext_req(o_ext_req), .i_opnd_req(o_opnd_req),
        .i_size(o_size), .i_imm(imm), .i_dst(dst), .i_src(src), .i_gap(gap),
        .o_ext_valid(i_ext_valid), .o_ext_word(i_ext_word), .o_opnd_valid(i_opnd_valid),
        .o_dst_data(i_dst_data), .o_src_data(i_src_data));

    task chk(input string name, input logic [36:0] seen, input logic [36:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task finish_test;
        $display("checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // {x,n,z,v,c,result}; byte and word keep upper bits
    function automatic logic [36:0] ref_sub(input logic [31:0] d, input logic [31:0] s,
                                            input logic x, input logic [1:0] sz);
        logic [32:0] t;
        logic [31:0] m;
        integer      w;
        w = (sz == `SFE_SZ_BYTE) ? 8 : (sz == `SFE_SZ_WORD) ? 16 : 32;
        m = (w == 32) ? 32'hFFFFFFFF : ((32'h1 << w) - 32'h1);
        t = {1'b0, d & m} - {1'b0, s & m} - {32'h0, x};
        return {t[w], t[w-1], (t[31:0] & m) == 32'h0, d[w-1] != s[w-1] && t[w-1] != d[w-1],
                t[w], (d & ~m) | (t[31:0] & m)};
    endfunction

    // offer one opcode, wait for its result or refusal
    task run(input logic [15:0] op);
        integer n;
        @(negedge i_sys_clk);
        while (o_ready !== 1'b1)
            @(negedge i_sys_clk);
        i_op_valid = 1'b1;
        i_opcode = op;
        @(negedge i_sys_clk);
        i_op_valid = 1'b0;
        n = 0;
        while (o_wr_valid !== 1'b1 && o_illegal !== 1'b1 && n < 40)
        begin
            @(negedge i_sys_clk);
            n++;
        end
    endtask

    task load(input logic [4:0] f);
        @(negedge i_sys_clk);
        i_flag_load = 1'b1;
        i_flag_value = f;
        @(negedge i_sys_clk);
        i_flag_load = 1'b0;
        ef = f;
        chk("flags", flg, f);
    endtask

    always @(posedge i_sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            error_cnt++;
            finish_test;
        end
    end

    initial
    begin
        repeat (3) @(negedge i_sys_clk);
        i_reset_n = 1'b1;
        gap = 4'h2;
        imm = 32'h0001_0081;
        dst = 32'h8000_7F00;
        for (i = 0; i < 3; i++)
        begin
            run({`SFE_OP_IMM_HI, i[1:0], `SFE_MD_DREG, 3'h2});
            r = ref_sub(dst, imm, 1'b0, i[1:0]);
            chk("size", o_size, i[1:0]);
            chk("result", o_result, r[31:0]);
            chk("flags", flg, r[36:32]);
        end
        run({`SFE_OP_IMM_HI, `SFE_SZ_WORD, `SFE_MD_EXT, `SFE_ABS_LONG});
        chk("mode", {o_dst_mode, o_dst_reg, o_src_used, o_wr_valid, o_ready, o_ext_req,
                     o_opnd_req}, 11'h72C);
        gap = 4'h0;
        dst = 32'h0000_0005;
        for (i = 0; i < 8; i++)
        begin
            run({`SFE_OP_QUICK_HI, i[2:0], 1'b1, `SFE_SZ_LONG, `SFE_MD_DREG, 3'h1});
            r = ref_sub(dst, (i == 0) ? 32'h8 : i, 1'b0, `SFE_SZ_LONG);
            chk("result", o_result, r[31:0]);
            chk("flags", flg, r[36:32]);
        end
        ef = r[36:32];
        dst = 32'h0001_0000;
        run({`SFE_OP_QUICK_HI, 3'h1, 1'b1, `SFE_SZ_WORD, `SFE_MD_AREG, 3'h3});
        chk("result", o_result, 32'h0000_FFFF);
        chk("flags", flg, ef);
        for (i = 0; i < 6; i++)
        begin
            run(bad_op[i]);
            chk("refused", {o_illegal, o_wr_valid}, 2'h2);
        end
        load(5'h14);
        for (i = 0; i < 3; i++)
        begin
            dst = ext_d[i];
            src = ext_s[i];
            run(ext_op[i]);
            r = ref_sub(dst, src, ef[4], ext_op[i][7:6]);
            ef = {r[36:35], r[34] & ef[2], r[33:32]};
            chk("result", o_result, r[31:0]);
            chk("flags", flg, ef);
            chk("regs", {o_predec, o_src_used, o_dst_reg, o_src_reg},
                {ext_op[i][3], 1'b1, ext_op[i][11:9], ext_op[i][2:0]});
        end
        load(5'h13);
        dst = 32'h8000_1234;
        run(16'h4845);
        chk("result", o_result, 32'h1234_8000);
        chk("flags", flg, 5'h10);
        finish_test;
    end
endmodule
